// ---- src/dsp_port.v ----
// Notes on behaviour
// (RULE_01) low reset_n resets everything at once; high releases it. The storage array mem is not cleared and keeps its data.
// (RULE_02) controller keeps reset_n high in normal operation.
// (RULE_03) data bit 0 is the write leveling reference bit.
// (RULE_04) read strobe toggles with each read beat, edge aligned.
// (RULE_05) controller centres write strobe on write data.
// (RULE_06) strobe always driven as true and complement pair.
// (RULE_07) mode bit 11 set gives termination strobe same termination.
// (RULE_08) mode bit 11 clear makes shared pin the write mask.
// (RULE_09) controller keeps mode bit 11 clear for wide parts.
// (RULE_10) input-only pins never get termination.
// (RULE_11) storage is eight independent banks.
// (RULE_12) each access moves one eight-beat word over four clocks. A chopped burst here moves four beats over two link clocks.
// (RULE_13) bursts start at column, eight beats or four when chopped.
// (RULE_14) controller activates a bank before reading or writing it.
// (RULE_15) activate takes bank from bank inputs, row from address.
// (RULE_16) read/write takes column; address bit 10 asks auto-precharge.
// (RULE_17) on-the-fly mode uses address bit 12 to pick burst length.
// (RULE_18) controller initialises the device before normal accesses.
// (RULE_19) address bit 12 high means full burst, low means chop.
// (RULE_20) precharge closes one bank, or all when bit 10 high.
// (RULE_21) chip select high masks every command.
// (RULE_22) write beats with write mask high are discarded.
// (RULE_23) commands decode from chip select, row, column, write enable.
`timescale 1ns/1ps
`include "dsp_regs.vh"
module dsp_port (
    input wire clk,
    input wire reset_n,
    input wire link_clk,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [`DSP_BA_W-1:0] bank_addr,
    input wire [`DSP_ROW_W-1:0] addr,
    input wire [`DSP_DQ_W-1:0] dq_in,
    output reg [`DSP_DQ_W-1:0] dq_out,
    output reg dq_oe,
    input wire strobe_in,
    output reg strobe_out,
    output reg strobe_out_n,
    output reg strobe_oe,
    input wire mask_pin,
    input wire chop_on_the_fly,
    input wire termination_enable,
    input wire odt_request,
    output reg termination_strobe_term,
    output reg strobe_term,
    output wire [`DSP_BANKS-1:0] bank_open,
    output wire level_feedback,
    output wire busy
);
    // pins pass two flops before use
    wire [`DSP_DQ_W+8:0] pins_s;
    dsp_sync #(.W(`DSP_DQ_W + 9)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d({link_clk, cs_n, ras_n, cas_n, we_n, strobe_in, mask_pin,
            odt_request, chop_on_the_fly, dq_in}),
        .q(pins_s)
    );
    wire lclk_s = pins_s[`DSP_DQ_W+8];
    wire [3:0] cmd_s = pins_s[`DSP_DQ_W+7:`DSP_DQ_W+4];
    wire dqs_s = pins_s[`DSP_DQ_W+3];
    wire dm_s = pins_s[`DSP_DQ_W+2];
    wire odt_s = pins_s[`DSP_DQ_W+1];
    wire otf_s = pins_s[`DSP_DQ_W];
    wire [`DSP_DQ_W-1:0] dq_s = pins_s[`DSP_DQ_W-1:0];
    // address pins pass two flops so they line up with the command bundle
    reg [`DSP_ROW_W-1:0] addr_meta_reg;
    reg [`DSP_BA_W-1:0] ba_meta_reg;
    reg [`DSP_ROW_W-1:0] addr_reg;
    reg [`DSP_BA_W-1:0] ba_reg;
    reg lclk_d_reg;
    reg dqs_d_reg;
    wire lrise = lclk_s & ~lclk_d_reg;
    wire dqs_edge = dqs_s ^ dqs_d_reg;

    localparam ST_IDLE = 2'h0;
    localparam ST_RLAT = 2'h1;
    localparam ST_READ = 2'h2;
    localparam ST_WRITE = 2'h3;

    reg [1:0] state_reg;
    reg [`DSP_ROW_W-1:0] row_reg [0:`DSP_BANKS-1];
    reg [`DSP_BANKS-1:0] open_reg;
    reg [`DSP_DQ_W-1:0] mem [0:(1<<`DSP_MEM_W)-1];
    reg [`DSP_BA_W-1:0] cur_bank_reg;
    reg [`DSP_COL_W-1:0] col_reg;
    reg [3:0] beat_reg;
    reg [3:0] beats_reg;
    reg [3:0] lat_reg;
    reg auto_pre_reg;
    integer i;

    // storage index: bank and low column bits
    function [`DSP_MEM_W-1:0] mem_index;
        input [`DSP_BA_W-1:0] b;
        input [`DSP_COL_W-1:0] c;
        input [3:0] beat;
        begin
            mem_index = {b, c[2:0] + beat[2:0]};
        end
    endfunction

    // (RULE_21) chip select masks
    // (RULE_23) truth table decode
    wire [3:0] cmd = cmd_s[3] ? `DSP_CMD_NOP : cmd_s;
    wire take = lrise & (state_reg == ST_IDLE);
    // (RULE_17) on-the-fly chop select
    // (RULE_19) bit 12 low chops
    wire chop = otf_s & ~addr_reg[`DSP_CHOP_BIT];
    wire [3:0] beats = chop ? `DSP_BEATS_CHOP : `DSP_BEATS_FULL;

    assign bank_open = open_reg;
    assign busy = (state_reg != ST_IDLE);
    // (RULE_03) bit 0 reference
    assign level_feedback = dq_s[0] & dqs_s;

    // (RULE_07) termination follows strobe
    // (RULE_08) mask mode leaves it unused
    // (RULE_10) only data side terminated
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_term <= 1'b0;
            termination_strobe_term <= 1'b0;
        end else begin
            strobe_term <= odt_s;
            termination_strobe_term <= odt_s & termination_enable;
        end
    end

    // (RULE_01) asynchronous reset
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            open_reg <= 8'h00;
            addr_meta_reg <= 14'h0000;
            ba_meta_reg <= 3'h0;
            addr_reg <= 14'h0000;
            ba_reg <= 3'h0;
            lclk_d_reg <= 1'b0;
            dqs_d_reg <= 1'b0;
            cur_bank_reg <= 3'h0;
            col_reg <= 10'h000;
            beat_reg <= 4'h0;
            beats_reg <= 4'h0;
            lat_reg <= 4'h0;
            auto_pre_reg <= 1'b0;
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
            strobe_out <= 1'b0;
            strobe_out_n <= 1'b1;
            strobe_oe <= 1'b0;
            for (i = 0; i < `DSP_BANKS; i = i + 1)
                row_reg[i] <= 14'h0000;
        end else begin
            lclk_d_reg <= lclk_s;
            dqs_d_reg <= dqs_s;
            addr_meta_reg <= addr;
            ba_meta_reg <= bank_addr;
            addr_reg <= addr_meta_reg;
            ba_reg <= ba_meta_reg;
            case (state_reg)
                ST_IDLE: begin
                    dq_oe <= 1'b0;
                    strobe_oe <= 1'b0;
                    if (take) begin
                        case (cmd)
                            // (RULE_11) eight banks
                            // (RULE_15) bank and row
                            `DSP_CMD_ACT: begin
                                open_reg[ba_reg] <= 1'b1;
                                row_reg[ba_reg] <= addr_reg;
                            end
                            // (RULE_20) one or all
                            `DSP_CMD_PRE: begin
                                if (addr_reg[`DSP_AUTO_PRE_BIT])
                                    open_reg <= 8'h00;
                                else
                                    open_reg[ba_reg] <= 1'b0;
                            end
                            // (RULE_14) open bank required
                            // (RULE_16) column and auto-precharge
                            `DSP_CMD_RD, `DSP_CMD_WR: begin
                                if (open_reg[ba_reg]) begin
                                    cur_bank_reg <= ba_reg;
                                    col_reg <= addr_reg[`DSP_COL_W-1:0];
                                    auto_pre_reg <=
                                        addr_reg[`DSP_AUTO_PRE_BIT];
                                    beats_reg <= beats;
                                    beat_reg <= 4'h0;
                                    lat_reg <= 4'h0;
                                    state_reg <= (cmd == `DSP_CMD_RD) ?
                                        ST_RLAT : ST_WRITE;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_RLAT: begin
                    if (lrise)
                        lat_reg <= lat_reg + 4'h1;
                    if (lrise && lat_reg == `DSP_READ_LAT - 4'h1) begin
                        state_reg <= ST_READ;
                        strobe_oe <= 1'b1;
                        dq_oe <= 1'b1;
                    end
                end
                // (RULE_04) strobe edge aligned
                // (RULE_06) differential pair
                // (RULE_12) two beats per link clock
                // (RULE_13) burst from column
                ST_READ: begin
                    if (lclk_s != lclk_d_reg) begin
                        if (beat_reg == beats_reg) begin
                            state_reg <= ST_IDLE;
                            dq_oe <= 1'b0;
                            strobe_oe <= 1'b0;
                            if (auto_pre_reg)
                                open_reg[cur_bank_reg] <= 1'b0;
                        end else begin
                            dq_out <= mem[mem_index(cur_bank_reg,
                                col_reg, beat_reg)];
                            strobe_out <= ~beat_reg[0];
                            strobe_out_n <= beat_reg[0];
                            beat_reg <= beat_reg + 4'h1;
                        end
                    end
                end
                ST_WRITE: begin
                    if (dqs_edge) begin
                        // (RULE_22) masked beat dropped
                        if (!(dm_s && !termination_enable))
                            mem[mem_index(cur_bank_reg, col_reg,
                                beat_reg)] <= dq_s;
                        beat_reg <= beat_reg + 4'h1;
                        if (beat_reg == beats_reg - 4'h1) begin
                            state_reg <= ST_IDLE;
                            if (auto_pre_reg)
                                open_reg[cur_bank_reg] <= 1'b0;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // dsp_port

// ---- shared/dsp_regs.vh ----
`ifndef DSP_REGS_VH
`define DSP_REGS_VH
// geometry
`define DSP_BANKS 8
`define DSP_BA_W 3
`define DSP_ROW_W 14
`define DSP_COL_W 10
`define DSP_DQ_W 8
`define DSP_MEM_W 6
// address field positions
`define DSP_AUTO_PRE_BIT 10
`define DSP_CHOP_BIT 12
// mode register one field position
`define DSP_MR1_TERM_BIT 11
// burst lengths in beats
`define DSP_BEATS_FULL 4'h8
`define DSP_BEATS_CHOP 4'h4
// command codes {cs_n, ras_n, cas_n, we_n}
`define DSP_CMD_MRS 4'h0
`define DSP_CMD_REF 4'h1
`define DSP_CMD_PRE 4'h2
`define DSP_CMD_ACT 4'h3
`define DSP_CMD_WR 4'h4
`define DSP_CMD_RD 4'h5
`define DSP_CMD_NOP 4'h7
// read latency in link clocks
`define DSP_READ_LAT 4'h2
`endif

// ---- src/dsp_sync.v ----
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of pin levels
module dsp_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire reset_n,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // first stage read only by second
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule // dsp_sync

// ---- tb/dsp_ctrl_model.sv ----
`timescale 1ns/1ps
// controller side: free running link clock and write bursts
module dsp_ctrl_model (
    input wire clk,
    output logic link_clk,
    output logic [7:0] dq_in,
    output logic strobe_in,
    output logic mask_pin
);
    // idle levels, then the link clock in its own phase
    initial begin
        link_clk = 1'b0;
        dq_in = 8'h00;
        strobe_in = 1'b0;
        mask_pin = 1'b0;
        #7;
        forever #80 link_clk = ~link_clk;
    end
    // one beat per half link clock, data settles before the edge
    task send(input [63:0] d, input [7:0] m, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            dq_in <= d[8*k+:8];
            mask_pin <= m[k];
            repeat (2) @(posedge clk);
            strobe_in <= ~strobe_in;
            @(posedge clk);
        end
        dq_in <= ~dq_in; // released bus shows no stale data
        mask_pin <= 1'b0;
    endtask
endmodule // dsp_ctrl_model

// ---- tb/dsp_port_checker.sv ----
`timescale 1ns/1ps
module dsp_port_checker (
    input wire clk,
    input wire reset_n,
    input wire cs_n,
    input wire busy,
    input wire [7:0] bank_open,
    input wire [7:0] dq_in,
    input wire strobe_in,
    input wire dq_oe,
    input wire strobe_oe,
    input wire strobe_out,
    input wire strobe_out_n,
    input wire termination_enable,
    input wire strobe_term,
    input wire termination_strobe_term,
    input wire level_feedback
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // start of a read burst on the pins
    sequence read_start;
        $rose(dq_oe);
    endsequence
    idle_reset_a: assert property (
        $rose(reset_n) |-> bank_open == 8'h00 && !dq_oe)
        else $error("state left after reset");
    level_ref_a: assert property (
        (dq_in[0] && strobe_in)[*4] |-> level_feedback)
        else $error("leveling feedback missing");
    read_strobe_a: assert property (
        dq_oe |-> strobe_oe) else $error("read data without strobe");
    diff_pair_a: assert property (
        strobe_oe |-> strobe_out_n == !strobe_out)
        else $error("strobe legs not complementary");
    term_copy_a: assert property (
        termination_enable[*3] |-> termination_strobe_term == strobe_term)
        else $error("termination strobe differs");
    term_off_a: assert property (
        (!termination_enable)[*3] |-> !termination_strobe_term)
        else $error("termination strobe used");
    read_len_a: assert property (
        read_start |-> dq_oe[*8] ##[13:29] !dq_oe)
        else $error("read burst length wrong");
    cs_mask_a: assert property (
        (cs_n && !busy)[*6] |=> $stable(bank_open))
        else $error("deselected command acted on");
endmodule // dsp_port_checker

// ---- tb/dsp_port_tb_top.sv ----
`timescale 1ns/1ps
`include "dsp_regs.vh"
module dsp_port_tb_top;
    logic clk = 1'b0, reset_n = 1'b0, link_clk, strobe_in, mask_pin;
    logic cs_n = 1'b1, ras_n = 1'b1, cas_n = 1'b1, we_n = 1'b1;
    logic chop_on_the_fly = 1'b1, termination_enable = 1'b0;
    logic odt_request = 1'b0, dq_oe, strobe_out, strobe_out_n, strobe_oe;
    logic strobe_term, termination_strobe_term, level_feedback, busy;
    logic [2:0] bank_addr = 3'h0;
    logic [13:0] addr = 14'h0000;
    logic [7:0] dq_in, dq_out, bank_open;
    logic [63:0] d1 = 64'h0F1E2D3C4B5B6978, d2 = 64'hA1B2C3D4E5F60718;
    logic [63:0] e3 = 64'hA1B2C3D44BF66918; // d2 with beats 1 and 3 masked, old d1 bytes kept there
    int mismatches = 0, checks_done = 0;
    dsp_port uut (
        .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr),
        .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .strobe_in(strobe_in), .strobe_out(strobe_out),
        .strobe_out_n(strobe_out_n), .strobe_oe(strobe_oe),
        .mask_pin(mask_pin), .chop_on_the_fly(chop_on_the_fly),
        .termination_enable(termination_enable),
        .odt_request(odt_request),
        .termination_strobe_term(termination_strobe_term),
        .strobe_term(strobe_term), .bank_open(bank_open),
        .level_feedback(level_feedback), .busy(busy)
    );
    dsp_ctrl_model ctl (
        .clk(clk), .link_clk(link_clk), .dq_in(dq_in),
        .strobe_in(strobe_in), .mask_pin(mask_pin)
    );
    // system clock
    always #10 clk = ~clk;
    // compare and count
    task chk(input string what, input logic [63:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: exp %h seen %h", what, exp, got);
        end
    endtask
    // command held from one link fall to the next
    task cmd(input [3:0] c, input [2:0] b, input [13:0] a);
        @(negedge link_clk);
        @(posedge clk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        bank_addr <= b;
        addr <= a;
        @(negedge link_clk);
        @(posedge clk);
        {cs_n, ras_n, cas_n, we_n} <= `DSP_CMD_NOP;
        addr <= ~a;
    endtask
    // read burst, one beat per strobe edge
    task rd(input [2:0] b, input [13:0] a, input [63:0] d, input int n);
        int k;
        logic p;
        k = 0;
        cmd(`DSP_CMD_RD, b, a);
        p = strobe_out;
        repeat (100) begin
            @(posedge clk);
            if (dq_oe === 1'b1 && strobe_out !== p) begin
                chk("read beat", d[8*k+:8], dq_out);
                k++;
            end
            p = strobe_out;
        end
        chk("beat count", n, k);
    endtask
    // verdict and end of run
    task close_out;
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("idle banks", 8'h00, bank_open);
        chk("strobe comp", 1'b1, strobe_out_n);
        cmd(`DSP_CMD_ACT | 4'h8, 3'h5, 14'h0000);
        chk("deselected", 8'h00, bank_open);
        cmd(`DSP_CMD_ACT, 3'h2, 14'h3FFF);
        cmd(`DSP_CMD_ACT, 3'h7, 14'h0001);
        chk("open banks", 8'h84, bank_open);
        cmd(`DSP_CMD_WR, 3'h2, 14'h1000);
        ctl.send(d1, 8'h00, 8);
        rd(3'h2, 14'h1000, d1, 8);
        rd(3'h2, 14'h0004, d1 >> 32, 4);
        cmd(`DSP_CMD_WR, 3'h2, 14'h1000);
        ctl.send(d2, 8'h0A, 8);
        rd(3'h2, 14'h1000, e3, 8);
        chop_on_the_fly <= 1'b0;
        rd(3'h2, 14'h0004, {e3[31:0], e3[63:32]}, 8);
        chop_on_the_fly <= 1'b1;
        termination_enable <= 1'b1;
        odt_request <= 1'b1;
        repeat (4) @(posedge clk);
        chk("strobe term", 1'b1, strobe_term);
        chk("term strobe", 1'b1, termination_strobe_term);
        termination_enable <= 1'b0;
        repeat (4) @(posedge clk);
        chk("term unused", 1'b0, termination_strobe_term);
        cmd(`DSP_CMD_PRE, 3'h7, 14'h0000);
        chk("one closed", 8'h04, bank_open);
        cmd(`DSP_CMD_PRE, 3'h0, 14'h0400);
        chk("all closed", 8'h00, bank_open);
        cmd(`DSP_CMD_ACT, 3'h2, 14'h0000);
        rd(3'h2, 14'h1400, e3, 8);
        chk("auto closed", 8'h00, bank_open);
        cmd(`DSP_CMD_ACT, 3'h5, 14'h0000);
        chk("bank five", 8'h20, bank_open);
        reset_n <= 1'b0;
        #1;
        chk("async clear", 8'h00, bank_open);
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(3'h2, 14'h1000, e3, 0);
        close_out;
    end
    // hang guard, far beyond the expected run
    initial begin
        #200000;
        mismatches++;
        close_out;
    end
endmodule // dsp_port_tb_top
bind dsp_port dsp_port_checker chkr (
    .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .busy(busy),
    .bank_open(bank_open), .dq_in(dq_in), .strobe_in(strobe_in),
    .dq_oe(dq_oe), .strobe_oe(strobe_oe), .strobe_out(strobe_out),
    .strobe_out_n(strobe_out_n), .termination_enable(termination_enable),
    .strobe_term(strobe_term),
    .termination_strobe_term(termination_strobe_term),
    .level_feedback(level_feedback)
);
